// >>> hdl/acs_pkg.sv
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: 250 MHz clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned 32-bit words
package acs_pkg;
  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  // Mode register fields
  localparam int MODE_CE_BIT = 0;
  localparam int MODE_CS_BIT = 1;
  localparam int MODE_SEL_LSB = 2;
  localparam int SEL_W = 2;
  // Result and channel widths
  localparam int RES_BITS = 10;
  localparam int CH_W = 2;
  // Status and mask fields
  localparam int STAT_W = 2;
  localparam int STAT_DONE = 0;
  localparam int STAT_SUSPECT = 1;
  // Timing: clock period and comparator warm-up time
  localparam int CLK_NS = 4;
  localparam int WARM_US = 14;
  localparam int WARM_CYC = (WARM_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WARM_W = 12;
  // Sequencer timing: base bit period in clocks, phase lengths in bit periods
  localparam logic [7:0] BASE_TICK = 8'h02;
  localparam int START_DELAY_TICKS = 2;
  localparam int SAMPLE_TICKS = 2;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT} acs_state_t;
  // Signals towards the analog front end
  typedef struct packed {
    logic sampleEn;
    logic [CH_W-1:0] chanSel;
    logic [RES_BITS-1:0] trialCode;
  } acs_afe_t;
endpackage

// >>> hdl/acs_sar_step.sv
// Purpose: Successive-approximation trial register
// Assumes: compBit answers the trial code that is on trialCode
// Notes: One bit is decided for each step pulse, MSB first
`timescale 1ns/1ps
module acs_sar_step #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic compBit,
  // Codes
  output logic [W-1:0] trialCode,
  output logic [W-1:0] finalCode
);
  // Bit under trial, one-hot
  logic [W-1:0] mask;

  // Elaboration check on the width
  if (W < 2) begin : g_bad_width
    $error("acs_sar_step: W must be at least 2");
  end

  // Value if this step is the last
  assign finalCode = compBit ? trialCode : (trialCode & ~mask);

  // Trial update: keep or drop the bit, try the next one
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      mask <= {1'b1, {(W-1){1'b0}}};
      trialCode <= {1'b1, {(W-1){1'b0}}};
    end else if (step) begin
      mask <= mask >> 1;
      trialCode <= finalCode | (mask >> 1);
    end
  end
endmodule

// >>> hdl/acs_sequencer.sv
// Purpose: APB-controlled sequencer for a four-input SAR converter
// Assumes: Front end inputs are synchronous to clk
// Notes: Behaviour
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module acs_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input wire logic [acs_pkg::DATA_W-1:0] pwdata,
  output logic [acs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  output acs_pkg::acs_afe_t afe,
  input wire logic compBit,
  // Interrupts
  output logic irq,
  output logic convEndIrq
);
  import acs_pkg::*;
  // Software-visible state
  logic compEnable;
  logic startBit;
  logic [SEL_W-1:0] sampleSel;
  logic [CH_W-1:0] chanSel;
  logic [RES_BITS-1:0] result;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  // Sequencer state
  acs_state_t state, next_state;
  logic [4:0] tickCnt;
  logic [7:0] divCnt;
  logic [7:0] tickLen;
  logic tick;
  logic sampling;
  logic [WARM_W-1:0] warmCnt;
  // Bus strobes and events
  logic wrEn, wrMode, wrChan, cfgWr, restart;
  logic eocRaw, eoc;
  logic startRise;
  logic [RES_BITS-1:0] finalCode;
  logic [RES_BITS-1:0] trialCode;

  // Address match used by read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Write strobes at the access edge
  assign wrEn = psel && penable && pready && pwrite;
  assign wrMode = wrEn && hit(paddr, OFS_MODE);
  assign wrChan = wrEn && hit(paddr, OFS_CHAN);
  assign cfgWr = wrMode || wrChan;
  assign startRise = wrMode && pwdata[MODE_CS_BIT] && !startBit;

  // Bit period, taking a mode write at once so a restart runs at the new length
  assign tickLen = BASE_TICK << (wrMode ? pwdata[MODE_SEL_LSB +: SEL_W] : sampleSel);
  assign tick = (state != ST_IDLE) && (divCnt == 8'h00);

  // Restart of the running conversion on reconfiguration
  assign restart = cfgWr && (state == ST_SAMPLE || state == ST_CONVERT);

  // End of the last bit, and the one that counts
  assign eocRaw = (state == ST_CONVERT) && tick && (tickCnt == 5'h00);
  assign eoc = eocRaw && !cfgWr;

  // Front end outputs, all from flip-flops
  assign afe = '{sampleEn: sampling, chanSel: chanSel, trialCode: trialCode};

  // Tick counts to load on entering a state
  function automatic logic [4:0] loadCount(input acs_state_t s);
    case (s)
      ST_DELAY: loadCount = 5'(START_DELAY_TICKS - 1);
      ST_SAMPLE: loadCount = 5'(SAMPLE_TICKS - 1);
      ST_CONVERT: loadCount = 5'(RES_BITS - 1);
      default: loadCount = 5'h00;
    endcase
  endfunction

  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = startBit ? ST_DELAY : ST_IDLE;
      ST_DELAY: next_state = (tick && tickCnt == 5'h00) ? ST_SAMPLE : ST_DELAY;
      ST_SAMPLE: next_state = (tick && tickCnt == 5'h00) ? ST_CONVERT : ST_SAMPLE;
      ST_CONVERT: next_state = eocRaw ? ST_SAMPLE : ST_CONVERT;
      default: next_state = ST_IDLE;
    endcase
    // Stop wins, then a reconfiguration restarts sampling
    if (!startBit) begin
      next_state = ST_IDLE;
    end else if (restart) begin
      next_state = ST_SAMPLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt <= 5'h00;
    end else if (next_state != state || restart) begin
      tickCnt <= loadCount(next_state);
    end else if (tick) begin
      tickCnt <= tickCnt - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt <= 8'h00;
    end else if (state == ST_IDLE || restart || divCnt == 8'h00) begin
      divCnt <= tickLen - 8'h01;
    end else begin
      divCnt <= divCnt - 8'h01;
    end
  end

  // Sampling switch follows the sample state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampling <= 1'b0;
    end else begin
      sampling <= (next_state == ST_SAMPLE);
    end
  end

  // SAR trial register
  acs_sar_step #(.W(RES_BITS)) u_sar (
    .clk(clk),
    .rst_n(rst_n),
    .clear(next_state == ST_SAMPLE),
    .step(state == ST_CONVERT && tick),
    .compBit(compBit),
    .trialCode(trialCode),
    .finalCode(finalCode)
  );

  // Comparator warm-up timer
  always_ff @(posedge clk) begin
    if (!rst_n || !compEnable) begin
      warmCnt <= '0;
    end else if (warmCnt != WARM_W'(WARM_CYC)) begin
      warmCnt <= warmCnt + 1'b1;
    end
  end

  // Mode and channel registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compEnable <= 1'b0;
      startBit <= 1'b0;
      sampleSel <= '0;
      chanSel <= '0;
    end else begin
      if (wrMode) begin
        compEnable <= pwdata[MODE_CE_BIT];
        startBit <= pwdata[MODE_CS_BIT];
        sampleSel <= pwdata[MODE_SEL_LSB +: SEL_W];
      end
      if (wrChan) begin
        chanSel <= pwdata[CH_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= '0;
    end else if (eoc) begin
      result <= finalCode;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      for (int i = 0; i < STAT_W; i++) begin
        if (wrEn && hit(paddr, OFS_STATUS) && pwdata[i]) begin
          status[i] <= 1'b0;
        end
      end
      // Set wins over a clear in the same cycle
      if (eoc) begin
        status[STAT_DONE] <= 1'b1;
      end
      if (startRise && (!pwdata[MODE_CE_BIT] || warmCnt != WARM_W'(WARM_CYC))) begin
        status[STAT_SUSPECT] <= 1'b1;
      end
    end
  end

  // Mask register and interrupt outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask <= '0;
      irq <= 1'b0;
      convEndIrq <= 1'b0;
    end else begin
      if (wrEn && hit(paddr, OFS_MASK)) begin
        mask <= pwdata[STAT_W-1:0];
      end
      irq <= |(status & mask);
      convEndIrq <= eoc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata <= '0;
        if (hit(paddr, OFS_MODE)) begin
          prdata <= DATA_W'({sampleSel, startBit, compEnable});
        end else if (hit(paddr, OFS_CHAN)) begin
          prdata <= DATA_W'(chanSel);
        end else if (hit(paddr, OFS_RESULT)) begin
          prdata <= DATA_W'(result);
        end else if (hit(paddr, OFS_STATUS)) begin
          prdata <= DATA_W'(status);
        end else if (hit(paddr, OFS_MASK)) begin
          prdata <= DATA_W'(mask);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Helper: cycles spent in sample and convert phases
  logic [15:0] sampCyc, convCyc;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sampCyc <= '0;
      convCyc <= '0;
    end else begin
      if (next_state == ST_SAMPLE) begin
        sampCyc <= (state != ST_SAMPLE || restart) ? 16'h0001 : sampCyc + 16'h0001;
      end
      if (next_state == ST_CONVERT) begin
        convCyc <= (state != ST_CONVERT) ? 16'h0001 : convCyc + 16'h0001;
      end
    end
  end
  // Completion sequence
  sequence s_complete;
    eoc ##1 convEndIrq;
  endsequence
  property p_sixth;
    @(posedge clk) disable iff (!rst_n) eocRaw |-> convCyc == 16'(5 * sampCyc);
  endproperty
  a_sixth: assert property (p_sixth) else $error("sample not one sixth");
  property p_done_kept;
    @(posedge clk) disable iff (!rst_n)
      wrChan && status[STAT_DONE] && !(wrEn && hit(paddr, OFS_STATUS)) |=> status[STAT_DONE];
  endproperty
  a_done_kept: assert property (p_done_kept) else $error("channel write cleared flag");
  property p_old_lands;
    @(posedge clk) disable iff (!rst_n) eoc ##1 wrChan |-> status[STAT_DONE];
  endproperty
  a_old_lands: assert property (p_old_lands) else $error("old result lost");
  property p_suspect;
    @(posedge clk) disable iff (!rst_n)
      startRise && warmCnt != WARM_W'(WARM_CYC) |=> status[STAT_SUSPECT];
  endproperty
  a_suspect: assert property (p_suspect) else $error("early start not flagged");
  property p_result_kept;
    @(posedge clk) disable iff (!rst_n) cfgWr |=> $stable(result);
  endproperty
  a_result_kept: assert property (p_result_kept) else $error("result changed on write");
  property p_sample_len;
    @(posedge clk) disable iff (!rst_n)
      state == ST_CONVERT && $past(state) == ST_SAMPLE |->
        sampCyc == 16'(SAMPLE_TICKS * tickLen);
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong");
  property p_start_delay;
    @(posedge clk) disable iff (!rst_n)
      state == ST_IDLE && startBit |=> !afe.sampleEn [*4];
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("no start delay");
  property p_read_first;
    @(posedge clk) disable iff (!rst_n)
      psel && !penable && hit(paddr, OFS_RESULT) && eoc |=> prdata == DATA_W'($past(result));
  endproperty
  a_read_first: assert property (p_read_first) else $error("read not served first");
  property p_write_wins;
    @(posedge clk) disable iff (!rst_n) eocRaw && cfgWr |=> !convEndIrq && $stable(result);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("completion not suppressed");
  property p_complete;
    @(posedge clk) disable iff (!rst_n)
      s_complete |-> status[STAT_DONE] && result == $past(finalCode);
  endproperty
  a_complete: assert property (p_complete) else $error("completion effects missing");
endmodule

// >>> dv/acs_afe_model.sv
// Purpose: Behavioural analog front end for the conversion sequencer
// Assumes: Input levels are given as ideal codes, one per channel
// Notes: Sample-and-hold plus ideal comparator
`timescale 1ns/1ps
module acs_afe_model
  import acs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests from the sequencer
  input wire acs_pkg::acs_afe_t afe,
  // Analog levels as codes
  input wire logic [3:0][acs_pkg::RES_BITS-1:0] vin,
  // Comparator answer
  output logic compBit
);
  // Level held on the sampling capacitor
  logic [RES_BITS-1:0] held;

  // Capacitor tracks the selected input only while sampling
  always_ff @(posedge clk) begin
    if (afe.sampleEn) begin
      held <= vin[afe.chanSel];
    end
  end

  // Held level compared with the trial code
  assign compBit = (held >= afe.trialCode);
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: One wait-free APB access, ideal front end model
// Notes: Seeded random input levels and channels
`timescale 1ns/1ps
module tb_top;
  import acs_pkg::*;
  // Design inputs and outputs
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rdat;
  logic pready, pslverr, irq, convEndIrq, compBit, rerr;
  acs_afe_t afe;
  logic [3:0][RES_BITS-1:0] vin = '0;
  // Counters and measurements
  int failures = 0;
  int total_checks = 0;
  int run = 0;
  int lastSample = 0;
  int gap = 0;
  int lastGap = 0;
  int cnt, ch;

  // Clock, 4 ns period
  always #2 clk = ~clk;

  acs_sequencer i_acs_sequencer (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .afe(afe), .compBit(compBit), .irq(irq), .convEndIrq(convEndIrq));
  acs_afe_model i_acs_afe_model (.clk(clk), .afe(afe), .vin(vin), .compBit(compBit));

  // Sample phase width and spacing of completions
  always @(posedge clk) begin
    if (afe.sampleEn === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      lastSample <= run;
      run <= 0;
    end
    gap <= (convEndIrq === 1'b1) ? 1 : gap + 1;
    if (convEndIrq === 1'b1) begin
      lastGap <= gap;
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
    // Answer taken at that same edge, then the request is released
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for a completion pulse, bounded
  task automatic wait_irq();
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (convEndIrq === 1'b1) break;
    end
    if (n == 3000) begin
      failures++;
      stop_test();
    end
    @(negedge clk);
  endtask

  // Interrupt level looked at mid-cycle
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask

  // Main sequence
  initial begin
    cnt = $urandom(32'h08847DA4);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    vin[0] <= 10'h3FF;
    vin[1] <= 10'($urandom);
    vin[2] <= 10'h000;
    vin[3] <= 10'($urandom);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdat, 32'h0);
      chk(32'(rerr), 32'(i == 5));
    end
    $display("test reset values done");
    ch = $urandom_range(3);
    apb(1'b1, OFS_CHAN, 32'(ch));
    apb(1'b1, OFS_MODE, 32'h3);
    for (cnt = 0; cnt < 100; cnt++) begin
      @(negedge clk);
      if (afe.sampleEn === 1'b1) break;
    end
    chk(32'(cnt > 1), 32'h1);
    wait_irq();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b0, OFS_RESULT, 32'h0);
    wait_irq();
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rdat, 32'(vin[ch]));
    $display("test first start done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_MODE, 32'(3 + 4 * s));
      wait_irq();
      wait_irq();
      chk(32'(lastSample), 32'(4 << s));
      chk(32'(lastGap), 32'(24 << s));
      apb(1'b0, OFS_RESULT, 32'h0);
      chk(rdat, 32'(vin[ch]));
    end
    $display("test sample select done");
    apb(1'b1, OFS_MODE, 32'h1);
    repeat (5) @(posedge clk);
    apb(1'b1, OFS_CHAN, 32'((ch + 1) % 4));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat & 32'h1, 32'h1);
    chk_irq(1'b0);
    apb(1'b1, OFS_MASK, 32'h1);
    chk_irq(1'b1);
    apb(1'b1, OFS_STATUS, 32'h3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h0);
    chk_irq(1'b0);
    $display("test flags and interrupt done");
    repeat (WARM_CYC + 100) @(posedge clk);
    ch = (ch + 1) % 4;
    apb(1'b1, OFS_MODE, 32'h3);
    wait_irq();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat, 32'h1);
    chk_irq(1'b1);
    wait_irq();
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rdat, 32'(vin[ch]));
    $display("test warm start done");
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h3);
    apb(1'b1, OFS_MODE, 32'h2);
    wait_irq();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat & 32'h2, 32'h2);
    $display("test disabled start done");
    stop_test();
  end
endmodule
